//--- verilog/ssr_pkg.sv
// Constants and types for the serial receiver with comma aligner.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
// How it works
// - Loopback select picks loop pair, else line
// - Lock to reference until data appears
// - Align enable high: keep searching for comma
// - Both comma forms detected and realign word
// - Comma flag high only with comma word
// - Align enable low: no realign, flag low
// - First bit on bit nine, last bit zero
// - Device makes word clock strobing word, flag
// - Phase select high: later clock, longer setup
// - Word clock rate follows selected rate mode
// - Rate select high lower, low higher rate
// - Realign delays word clock; bits may drop
// - Word stable at word clock rising edge
// - Synchronize within 1 ms, or 200 us
package ssr_pkg;
    localparam int unsigned WORD_W    = 10;            // Word width
    localparam logic [9:0]  K28_NEG   = 10'h0FA;       // 0011111010
    localparam logic [9:0]  K28_POS   = 10'h305;       // 1100000101
    localparam logic [3:0]  LAST_POS  = 4'h9;          // Last bit slot
    localparam logic [3:0]  RISE_EARLY = 4'h4;         // Clock rise, short setup
    localparam logic [3:0]  RISE_LATE = 4'h6;          // Clock rise, long setup
    localparam logic [3:0]  OVS_HI    = 4'h4;          // Cycles per bit, higher rate
    localparam logic [3:0]  OVS_LO    = 4'h8;          // Cycles per bit, lower rate
    localparam logic [5:0]  LOSS_BITS = 6'h28;         // Quiet bits before signal loss
    localparam logic [3:0]  ACQ_EDGES = 4'h8;          // Edges needed to lock on data
    localparam int          CLK_MHZ   = 100;           // Clock rate
    localparam int          SYNC_US   = 1000;          // Sync time from reset
    localparam int          RESYNC_US = 200;           // Sync time after data returns
    localparam int          SYNC_CYC  = SYNC_US * CLK_MHZ;
    localparam int          RESYNC_CYC = RESYNC_US * CLK_MHZ;
    localparam logic [11:0] REG_CTRL  = 12'h000;       // Control
    localparam logic [11:0] REG_STAT  = 12'h004;       // Status
    localparam logic [11:0] REG_WORD  = 12'h008;       // Last word and flag
    localparam logic [11:0] REG_CCNT  = 12'h00C;       // Comma count
    localparam int          CB_LOOP   = 0;             // Loopback select bit
    localparam int          CB_ALIGN  = 1;             // Align enable bit
    localparam int          CB_PHASE  = 2;             // Strobe phase select bit
    localparam int          CB_RATE   = 3;             // Line rate select bit
    localparam logic [3:0]  CTRL_RST  = 4'h2;          // Align on, higher rate
    typedef enum logic [1:0] {
        ST_REF  = 2'b01,                               // Locked to reference
        ST_DATA = 2'b10                                // Locked to data
    } ssr_lock_e;
endpackage : ssr_pkg

//--- verilog/ssr_bit_if.sv
// Recovered bit stream passed from clock recovery to the deserializer.
// Assumes both ends share the one system clock.
`timescale 1ns/1ns
interface ssr_bit_if;
    logic bit_stb;                                     // One-cycle bit strobe
    logic bit_val;                                     // Recovered bit
    logic locked;                                      // Locked to data
    modport src (output bit_stb, output bit_val, output locked);
    modport snk (input bit_stb, input bit_val, input locked);
endinterface : ssr_bit_if

//--- verilog/ssr_cdr.sv
// Clock recovery: picks bit centres from edges, falls back to reference.
// Assumes the serial input is already registered by the caller.
`timescale 1ns/1ns
module ssr_cdr
    import ssr_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ser_in,
    input  wire logic ref_clk,
    input  wire logic lower_rate,
    ssr_bit_if.src    bs
);
    ssr_lock_e  st_q, st_d;                            // Lock source
    logic       prev_q, prev_d;                        // Last serial level
    logic       refp_q, refp_d;                        // Last reference level
    logic [3:0] ph_q, ph_d;                            // Bit phase counter
    logic [5:0] quiet_q, quiet_d;                      // Bits without an edge
    logic [3:0] acq_q, acq_d;                          // Edges seen in ref mode
    logic [3:0] per;                                   // Cycles per bit
    logic       edg, stb;

    // Next state: data edges retime the phase, reference edges when idle
    always_comb begin
        per     = lower_rate ? OVS_LO : OVS_HI;
        edg     = ser_in ^ prev_q;
        stb     = (ph_q == 4'h0);
        prev_d  = ser_in;
        refp_d  = ref_clk;
        st_d    = st_q;
        acq_d   = acq_q;
        quiet_d = quiet_q;
        ph_d    = stb ? per - 4'h1 : ph_q - 4'h1;
        unique case (st_q)
            ST_REF: begin
                // Free-run on reference so the loop stays near rate
                if (ref_clk && !refp_q) ph_d = per - 4'h1;
                if (edg) begin
                    ph_d  = {1'b0, per[3:1]};
                    acq_d = acq_q + 4'h1;
                    if (acq_q == ACQ_EDGES - 4'h1) st_d = ST_DATA;
                end
                quiet_d = 6'h00;
            end
            ST_DATA: begin
                // Sample mid-bit: an edge puts the strobe half a bit later
                if (edg) ph_d = {1'b0, per[3:1]};
                if (edg) quiet_d = 6'h00;
                else if (stb) quiet_d = quiet_q + 6'h01;
                if (quiet_q >= LOSS_BITS) begin
                    st_d  = ST_REF;                    // No signal: back to
                    acq_d = 4'h0;
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q    <= ST_REF;
            prev_q  <= 1'b0;
            refp_q  <= 1'b0;
            ph_q    <= 4'h0;
            quiet_q <= 6'h00;
            acq_q   <= 4'h0;
        end else begin
            st_q    <= st_d;
            prev_q  <= prev_d;
            refp_q  <= refp_d;
            ph_q    <= ph_d;
            quiet_q <= quiet_d;
            acq_q   <= acq_d;
        end
    end

    assign bs.bit_stb = stb && (st_q == ST_DATA);
    assign bs.bit_val = ser_in;
    assign bs.locked  = (st_q == ST_DATA);

    a_loss_to_ref: assert property (@(posedge clk) disable iff (srst)
        (st_q == ST_DATA && quiet_q >= LOSS_BITS) |=> st_q == ST_REF)
        else $error("no fallback to reference after signal loss");
    a_acq_to_data: assert property (@(posedge clk) disable iff (srst)
        (st_q == ST_REF && edg && acq_q == ACQ_EDGES - 4'h1) |=> st_q == ST_DATA)
        else $error("no lock to data after acquisition");
endmodule : ssr_cdr

//--- verilog/ssr_deser.sv
// Deserializer with comma search and realignment.
// Assumes one bit strobe at most per clock from clock recovery.
`timescale 1ns/1ns
module ssr_deser
    import ssr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       align_en,
    ssr_bit_if.snk          bs,
    output logic [9:0]      word_q,
    output logic            comma_q,
    output logic            load_q,
    output logic [3:0]      pos_q
);
    logic [9:0] sh_q, sh_d;                            // Bit shifter
    logic [9:0] word_d;
    logic       comma_d, load_d, hit;
    logic [3:0] pos_d;

    // Shift, detect comma at every offset, load word on tenth bit or comma
    always_comb begin
        sh_d    = bs.bit_stb ? {sh_q[8:0], bs.bit_val} : sh_q;
        hit     = (sh_d == K28_NEG) || (sh_d == K28_POS);
        word_d  = word_q;
        comma_d = comma_q && align_en;                 // Flag off at once
        load_d  = 1'b0;
        pos_d   = pos_q;
        if (bs.bit_stb) begin
            if (align_en && hit) begin
                // Realign: boundary moves, partial word is dropped
                word_d  = sh_d;
                comma_d = 1'b1;
                load_d  = 1'b1;
                pos_d   = 4'h0;
            end else if (pos_q == LAST_POS) begin
                word_d  = sh_d;
                comma_d = 1'b0;
                load_d  = 1'b1;
                pos_d   = 4'h0;
            end else begin
                pos_d   = pos_q + 4'h1;
            end
        end
    end

    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            sh_q    <= 10'h000;
            word_q  <= 10'h000;
            comma_q <= 1'b0;
            load_q  <= 1'b0;
            pos_q   <= 4'h0;
        end else begin
            sh_q    <= sh_d;
            word_q  <= word_d;
            comma_q <= comma_d;
            load_q  <= load_d;
            pos_q   <= pos_d;
        end
    end

    a_comma_realign: assert property (@(posedge clk) disable iff (srst)
        (bs.bit_stb && align_en && hit) |=> comma_q && pos_q == 4'h0 && word_q == $past(sh_d))
        else $error("comma did not realign the word");
    a_comma_is_k28: assert property (@(posedge clk) disable iff (srst)
        comma_q |-> (word_q == K28_NEG || word_q == K28_POS))
        else $error("comma flag with a non-comma word");
    a_word_tenth: assert property (@(posedge clk) disable iff (srst)
        (bs.bit_stb && pos_q == LAST_POS && !(align_en && hit))
        |=> load_q && !comma_q && word_q == $past(sh_d))
        else $error("word not loaded after ten bits");
endmodule : ssr_deser

//--- verilog/ssr_top.sv
// Serial receiver top: input select, clock recovery, deserializer,
// received-word clock and an APB register slave.
// Assumes all inputs are synchronous to clk and APB is 32 bits wide.
`timescale 1ns/1ns
module ssr_top
    import ssr_pkg::*;
#(
    parameter int SYNC_CYCLES   = SYNC_CYC,            // Sync limit from reset
    parameter int RESYNC_CYCLES = RESYNC_CYC           // Sync limit after loss
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        line_input_pair,
    input  wire logic        loop_input_pair,
    input  wire logic        reference_clock,
    output logic [9:0]       recv_word,
    output logic             comma_found,
    output logic             recv_word_clock,
    output logic             sync_late
);
    ssr_bit_if bs ();                                  // Recovered bit stream

    // Control register and its fields
    logic [3:0]  ctrl_q, ctrl_d;
    logic        loop_sel, align_en, phase_sel, rate_lo;
    // Serial input after the selector
    logic        ser_q, ser_d;
    // Deserializer outputs
    logic [9:0]  word;
    logic        comma, load;
    logic [3:0]  pos;
    // Word clock
    logic        wclk_q, wclk_d;
    logic [3:0]  rise_pos;
    // Sync timer
    logic [16:0] tmr_q, tmr_d;
    logic        late_q, late_d;
    logic        had_q, had_d;
    logic [16:0] limit;
    // Comma counter
    logic [15:0] ccnt_q, ccnt_d;
    // APB answer
    logic        rdy_q, rdy_d;
    logic        err_q, err_d;
    logic [31:0] rd_q, rd_d;
    logic        acc, wr;

    assign loop_sel  = ctrl_q[CB_LOOP];
    assign align_en  = ctrl_q[CB_ALIGN];
    assign phase_sel = ctrl_q[CB_PHASE];
    assign rate_lo   = ctrl_q[CB_RATE];

    // Input selector, registered so recovery sees a clean level
    always_comb begin
        ser_d = loop_sel ? loop_input_pair : line_input_pair;
    end

    always_ff @(posedge clk) begin
        if (srst) ser_q <= 1'b0;
        else      ser_q <= ser_d;
    end

    // Clock recovery; the reference only steers it while no data is seen
    ssr_cdr u_cdr (
        .clk        (clk),
        .srst       (srst),
        .ser_in     (ser_q),
        .ref_clk    (reference_clock),                 // Rate supplied outside
        .lower_rate (rate_lo),
        .bs         (bs.src)
    );

    // Deserializer and comma aligner
    ssr_deser u_deser (
        .clk      (clk),
        .srst     (srst),
        .align_en (align_en),
        .bs       (bs.snk),
        .word_q   (word),
        .comma_q  (comma),
        .load_q   (load),
        .pos_q    (pos)
    );

    // Word clock: low while a new word settles, high from the rise slot on.
    // A realign restarts the slot count, which stretches the low phase and
    // so delays the clock to the new boundary. Its period follows the bit
    // period, so the rate select sets its frequency.
    always_comb begin
        rise_pos = phase_sel ? RISE_LATE : RISE_EARLY;
        wclk_d   = bs.locked && (pos >= rise_pos);
    end

    always_ff @(posedge clk) begin
        if (srst) wclk_q <= 1'b0;
        else      wclk_q <= wclk_d;
    end

    // Sync timer: runs while not locked on data, flags a late lock.
    // The first lock gets the long limit, later relocks the short one.
    always_comb begin
        limit  = had_q ? RESYNC_CYCLES[16:0] : SYNC_CYCLES[16:0];
        tmr_d  = tmr_q;
        late_d = late_q;
        had_d  = had_q || bs.locked;
        if (bs.locked) begin
            tmr_d  = 17'h00000;
            late_d = 1'b0;
        end else if (tmr_q == limit - 17'h00001) begin
            late_d = 1'b1;
        end else begin
            tmr_d  = tmr_q + 17'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tmr_q  <= 17'h00000;
            late_q <= 1'b0;
            had_q  <= 1'b0;
        end else begin
            tmr_q  <= tmr_d;
            late_q <= late_d;
            had_q  <= had_d;
        end
    end

    // Comma counter, wraps; shows the aligner at work
    always_comb begin
        ccnt_d = (load && comma) ? ccnt_q + 16'h0001 : ccnt_q;
    end

    always_ff @(posedge clk) begin
        if (srst) ccnt_q <= 16'h0000;
        else      ccnt_q <= ccnt_d;
    end

    // APB slave: one wait state. Read data and error are registered in the
    // first access cycle and shown with pready in the second; a write takes
    // effect at the edge where pready is sampled high.
    always_comb begin
        acc    = psel && penable && rdy_q;
        wr     = acc && pwrite;
        rdy_d  = psel && penable && !rdy_q;
        err_d  = 1'b0;
        rd_d   = 32'h0000_0000;
        ctrl_d = ctrl_q;
        if (rdy_d) begin
            unique case (paddr)
                REG_CTRL: rd_d = {28'h0000000, ctrl_q};
                REG_STAT: rd_d = {29'h00000000, late_q, bs.locked, wclk_q};
                REG_WORD: rd_d = {21'h000000, comma, word};
                REG_CCNT: rd_d = {16'h0000, ccnt_q};
                default:  err_d = 1'b1;                // Unmapped address
            endcase
        end
        if (wr && paddr == REG_CTRL) ctrl_d = pwdata[3:0];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
            rdy_q  <= 1'b0;
            err_q  <= 1'b0;
            rd_q   <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            rdy_q  <= rdy_d;
            err_q  <= err_d;
            rd_q   <= rd_d;
        end
    end

    // Outputs, all straight from flip-flops
    assign prdata          = rd_q;
    assign pready          = rdy_q;
    assign pslverr         = err_q;
    assign recv_word       = word;
    assign comma_found     = comma;
    assign recv_word_clock = wclk_q;
    assign sync_late       = late_q;

    // Checks
    a_input_select: assert property (@(posedge clk) disable iff (srst)
        ##1 ser_q == $past(ctrl_q[CB_LOOP] ? loop_input_pair : line_input_pair))
        else $error("serial input from wrong pair");
    a_comma_off: assert property (@(posedge clk) disable iff (srst)
        !align_en |=> !comma_found)
        else $error("comma flag high with align disabled");
    a_word_stable: assert property (@(posedge clk) disable iff (srst)
        $rose(recv_word_clock) |-> $stable(recv_word) && $stable(comma_found))
        else $error("word changed at word clock rise");
    a_clock_phase: assert property (@(posedge clk) disable iff (srst)
        (bs.locked && $past(bs.locked) && $rose(recv_word_clock))
        |-> $past(pos) >= ($past(phase_sel) ? RISE_LATE : RISE_EARLY))
        else $error("word clock rose before its slot");
    a_clock_low_load: assert property (@(posedge clk) disable iff (srst)
        (load && $past(bs.locked)) |=> !recv_word_clock [*3])
        else $error("word clock not held low after a new word");
endmodule : ssr_top

//--- tb/ssr_far_model.sv
// Far-end model: serializes queued words onto the chosen serial input and
// makes the reference clock from the current bit period.
// Assumes the bench sets the bit period in system clock cycles.
`timescale 1ns/1ns
module ssr_far_model (
    input  wire logic       clk,
    input  wire logic [3:0] bit_cycles,
    input  wire logic       use_loop,
    input  wire logic       no_signal,
    output logic            line_out,
    output logic            loop_out,
    output logic            ref_out
);
    logic [9:0] words[$];        // Words waiting to go out
    int         bit_n = 0;       // Bit slot within current word
    int         cnt = 0;         // Clocks left in current bit
    int         ref_cnt = 0;     // Reference half-period counter
    logic       ref_q = 1'b0;    // Reference level
    logic       cur = 1'b0;      // Bit on the wire
    logic       active = 1'b0;   // A word is being sent
    logic       idle_t = 1'b0;   // Idle pattern, never a stale level

    // Bench pushes whole words only
    task automatic push(input logic [9:0] w);
        words.push_back(w);
    endtask : push

    // Half period of 20 bits gives one reference cycle per 40 bits
    always @(posedge clk) begin
        if (ref_cnt >= 20 * int'(bit_cycles) - 1) begin
            ref_cnt <= 0;
            ref_q <= ~ref_q;
        end else begin
            ref_cnt <= ref_cnt + 1;
        end
    end

    // Each bit stands bit_cycles clocks, word bit nine first
    always @(posedge clk) begin
        idle_t <= ~idle_t;
        if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if (words.size() > 0) begin
            cur <= words[0][9 - bit_n];
            active <= 1'b1;
            cnt <= int'(bit_cycles) - 1;
            if (bit_n == 9) begin
                bit_n <= 0;
                void'(words.pop_front());
            end else begin
                bit_n <= bit_n + 1;
            end
        end else begin
            active <= 1'b0;
        end
    end

    // Silent line sits low; idle or unselected input toggles every clock
    assign line_out = no_signal ? 1'b0 : (active && !use_loop) ? cur : idle_t;
    assign loop_out = no_signal ? 1'b0 : (active && use_loop) ? cur : idle_t;
    assign ref_out  = ref_q;
endmodule : ssr_far_model

//--- tb/ssr_top_tb.sv
// Testbench: registers over APB, serial stream from the far-end model.
// Assumes short sync limits so the run stays brief.
`timescale 1ns/1ns
module ssr_top_tb;
    import ssr_pkg::*;
    logic        clk = 1'b0;             // System clock
    logic        srst = 1'b1;            // Reset, held at start
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        line_in;
    logic        loop_in;
    logic        ref_in;
    logic [9:0]  recv_word;
    logic        comma_found;
    logic        recv_word_clock;
    logic        sync_late;
    logic [3:0]  bit_cyc = OVS_HI;       // Far-end bit period
    logic        use_loop = 1'b0;        // Far end drives loop input
    logic        no_sig = 1'b1;          // Far end starts silent
    int          fails = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    logic        er;

    always #5 clk = ~clk;

    ssr_top #(.SYNC_CYCLES(200), .RESYNC_CYCLES(100)) dut (
        .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_input_pair(line_in), .loop_input_pair(loop_in),
        .reference_clock(ref_in), .recv_word(recv_word), .comma_found(comma_found),
        .recv_word_clock(recv_word_clock), .sync_late(sync_late));

    ssr_far_model far (.clk(clk), .bit_cycles(bit_cyc), .use_loop(use_loop),
        .no_signal(no_sig), .line_out(line_in), .loop_out(loop_in), .ref_out(ref_in));

    // Single exit point of the run
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    task automatic hang(input string msg);
        fails++;
        $display("BAD %0t timeout %s", $time, msg);
        report_and_stop();
    endtask : hang

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang("apb");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Wait for a given word; cyc counts clocks from the call to the match
    task automatic wait_word(input logic [9:0] w, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (recv_word !== w && cyc < 1000);
        if (cyc >= 1000) hang("word");
    endtask : wait_word

    // Preamble for lock, both comma forms, then two data words
    task automatic send_stream;
        for (int i = 0; i < 4; i++) far.push(10'h2AA);
        far.push(K28_NEG);
        far.push(K28_POS);
        far.push(10'h2D2);
        far.push(10'h14B);
    endtask : send_stream

    // Flag may only stand beside a comma word
    always @(posedge clk) begin
        if (srst === 1'b0 && comma_found === 1'b1) begin
            chk(recv_word === K28_NEG || recv_word === K28_POS, "flag on data");
        end
    end

    task automatic sc_sync;
        int n;
        n = 0;
        while (sync_late !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 190 && n <= 210, "sync timer");
    endtask : sc_sync

    task automatic sc_regs;
        apb(1'b0, REG_CTRL, 32'h0, rd, er);
        chk(rd === {28'h0, CTRL_RST} && er === 1'b0, "ctrl reset");
        apb(1'b1, REG_STAT, 32'hFFFF_FFFF, rd, er);
        apb(1'b0, REG_STAT, 32'h0, rd, er);
        chk(rd[1] === 1'b0, "locked with no signal");
        apb(1'b0, 12'h010, 32'h0, rd, er);
        chk(er === 1'b1 && rd === 32'h0, "unmapped access");
    endtask : sc_regs

    // Aligned run; rise returns clocks from data load to strobe rise
    task automatic sc_align(input logic [3:0] ctrl, output int rise);
        int c;
        int per;
        per = ctrl[CB_RATE] ? int'(OVS_LO) : int'(OVS_HI);
        apb(1'b1, REG_CTRL, {28'h0, ctrl}, rd, er);
        bit_cyc <= ctrl[CB_RATE] ? OVS_LO : OVS_HI;
        use_loop <= ctrl[CB_LOOP];
        no_sig <= 1'b0;
        send_stream();
        wait_word(K28_NEG, c);
        chk(comma_found === 1'b1, "no flag on first comma form");
        wait_word(K28_POS, c);
        chk(comma_found === 1'b1, "no flag on second comma form");
        chk(c == 10 * per, "comma spacing");
        wait_word(10'h2D2, c);
        chk(comma_found === 1'b0 && c == 10 * per, "data word");
        rise = 0;
        while (recv_word_clock !== 1'b0 && rise < 100) begin
            @(posedge clk);
            rise++;
        end
        while (recv_word_clock !== 1'b1 && rise < 100) begin
            @(posedge clk);
            rise++;
        end
        if (rise >= 100) hang("strobe");
        chk(recv_word === 10'h2D2, "word moved before strobe");
        wait_word(10'h14B, c);
        apb(1'b0, REG_WORD, 32'h0, rd, er);
        chk(rd === 32'h0000_014B, "word register");
        apb(1'b0, REG_STAT, 32'h0, rd, er);
        chk(rd[1] === 1'b1, "not locked on data");
    endtask : sc_align

    task automatic sc_phase;
        int d0;
        int d1;
        sc_align(4'h2, d0);
        sc_align(4'h6, d1);
        chk(d1 > d0, "phase select did not delay strobe");
    endtask : sc_phase

    task automatic sc_loop;
        int d;
        sc_align(4'h3, d);
    endtask : sc_loop

    task automatic sc_rate;
        int d;
        sc_align(4'hA, d);
    endtask : sc_rate

    // Commas sent with alignment off must never raise the flag
    task automatic sc_align_off;
        apb(1'b1, REG_CTRL, 32'h0, rd, er);
        bit_cyc <= OVS_HI;
        use_loop <= 1'b0;
        send_stream();
        for (int n = 0; n < 500; n++) begin
            @(posedge clk);
            chk(comma_found === 1'b0, "flag with align off");
        end
    endtask : sc_align_off

    // Silence after lock: fall back to reference, then the short limit runs out
    task automatic sc_loss;
        int n;
        no_sig <= 1'b1;
        n = 0;
        while (sync_late !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        chk(n >= 240 && n <= 300, "resync timer after loss");
        apb(1'b0, REG_STAT, 32'h0, rd, er);
        chk(rd[2:1] === 2'b10, "still locked after loss");
    endtask : sc_loss

    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        sc_sync();
        sc_regs();
        sc_phase();
        sc_loop();
        sc_rate();
        sc_align_off();
        sc_loss();
        report_and_stop();
    end
endmodule : ssr_top_tb
